// file: include/pwm_stop_pkg.sv
// Package: register map, field layouts, timing counts and carrier types
package pwm_stop_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned PWM_PERIOD_NS = 20_000;
	localparam int unsigned PWM_PERIOD_CYC = PWM_PERIOD_NS / 5;
	localparam int unsigned PWM_DUTY_PCT = 50;
	localparam int unsigned PWM_HIGH_CYC = PWM_PERIOD_CYC * PWM_DUTY_PCT / 100;
	localparam int unsigned TICK_MS = 10;
	localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;

	localparam logic [7:0] ADDR_RESET_CTL = 8'h00;
	localparam logic [7:0] ADDR_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
	localparam logic [7:0] ADDR_PERIOD = 8'h14;
	localparam logic [7:0] ADDR_DUTY = 8'h18;

	localparam int RST_BIT = 0;
	localparam logic [7:0] RESET_CTL_RST = 8'h01;
	localparam int CTL_RELEASE1 = 0;
	localparam int CTL_DEFAULT_LVL = 1;
	localparam int CTL_ACTIVE_LOW = 2;
	localparam logic [7:0] CONTROL_RST = 8'h00;

	localparam int EV_STOP1 = 0;
	localparam int EV_STOP2 = 1;
	localparam int EV_CMP_RISE = 2;
	localparam int EV_CMP_FALL = 3;
	localparam int EV_RESTART = 4;
	localparam int EV_TICK = 5;
	localparam int EV_PERIOD = 6;
	localparam int NUM_EV = 7;

	typedef struct packed {
		logic [2:0] cmp;
		logic [2:0] stop;
		logic [2:0] restart;
	} pin_sync_t;

	typedef struct packed {
		logic out;
		logic oe;
	} pin_drive_t;
endpackage

// file: design/edge_sync.sv
// Three-stage pin synchroniser with agreed-edge detection
`timescale 1ns/100ps
module edge_sync
	import pwm_stop_pkg::*;
#(
	parameter logic RST_LVL = 1'b0
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	typedef struct packed {
		logic [2:0] sh;
		logic level;
		logic rise;
		logic fall;
	} sync_st_t;

	sync_st_t st_r;
	sync_st_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.sh = {st_r.sh[1:0], pin};
		st_nxt.rise = 1'b0;
		st_nxt.fall = 1'b0;
		if (st_r.sh[1] == st_r.sh[2] && st_r.sh[2] != st_r.level)
		begin
			st_nxt.level = st_r.sh[2];
			st_nxt.rise = st_r.sh[2];
			st_nxt.fall = ~st_r.sh[2];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '{sh: {3{RST_LVL}}, level: RST_LVL, rise: 1'b0, fall: 1'b0};
		else
			st_r <= st_nxt;
	end

	assign level = st_r.level;
	assign rise = st_r.rise;
	assign fall = st_r.fall;
endmodule

// file: design/pwm_forced_output_stop.sv
// PWM channel with comparator and pin forced output stop, APB registers
`timescale 1ns/100ps
// Contract
// - Comparator rise enters stop one, Hi-Z
// - Release write resumes output next period
// - Stop pin fall enters stop two, low
// - Stop two ends period after pin rises
// - 20 us period, 50 percent duty
// - Standalone, default low, active high
// - Restart pin rising restarts counter, waveform
// - Stop one type 4, stop two type 2
// - Comparator triggers one, stop pin two
// - Comparator reports both edges
// - Interval tick every 10 ms
// - Reset bit one holds timer reset
// - Release honoured only with comparator low
module pwm_forced_output_stop
	import pwm_stop_pkg::*;
#(
	parameter int unsigned CNT_W = 16,
	parameter int unsigned TICK_COUNT = TICK_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic overcurrent_comparator,
	input wire logic stop_trigger_input,
	input wire logic restart_trigger_input,
	output logic pwm_out_one,
	output logic pwm_out_one_oe,
	output logic irq
);
	typedef struct packed {
		logic [7:0] rst_ctl;
		logic [7:0] ctl;
		logic [CNT_W-1:0] period;
		logic [CNT_W-1:0] duty;
		logic [CNT_W-1:0] cnt;
		logic [31:0] tick_cnt;
		logic stop1;
		logic stop2;
		logic stop1_rel;
		logic stop2_rel;
		logic [NUM_EV-1:0] ev_stat;
		logic [NUM_EV-1:0] ev_mask;
		logic [31:0] rdata;
		logic ready;
		logic err;
		pin_drive_t drv;
		logic irq;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic cmp_lvl, cmp_rise, cmp_fall;
	logic stp_lvl, stp_rise, stp_fall;
	logic rs_rise;

	function automatic logic addr_hit(input logic [31:0] a, input logic [7:0] off);
		addr_hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
	endfunction

	function automatic logic mapped(input logic [31:0] a);
		mapped = addr_hit(a, ADDR_RESET_CTL) || addr_hit(a, ADDR_CONTROL) ||
			addr_hit(a, ADDR_STATUS) || addr_hit(a, ADDR_IRQ_STAT) ||
			addr_hit(a, ADDR_IRQ_MASK) || addr_hit(a, ADDR_PERIOD) ||
			addr_hit(a, ADDR_DUTY);
	endfunction

	edge_sync u_cmp_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin(overcurrent_comparator),
		.level(cmp_lvl),
		.rise(cmp_rise),
		.fall(cmp_fall)
	);

	edge_sync #(.RST_LVL(1'b1)) u_stop_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin(stop_trigger_input),
		.level(stp_lvl),
		.rise(stp_rise),
		.fall(stp_fall)
	);

	edge_sync u_restart_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin(restart_trigger_input),
		.level(),
		.rise(rs_rise),
		.fall()
	);

	always_comb
	begin
		logic wr_en;
		logic rd_en;
		logic timer_rst;
		logic period_end;
		logic wave;
		logic [NUM_EV-1:0] ev;
		logic [NUM_EV-1:0] w1c;
		wr_en = 1'b0;
		rd_en = 1'b0;
		timer_rst = 1'b0;
		period_end = 1'b0;
		wave = 1'b0;
		ev = '0;
		w1c = '0;
		st_nxt = st_r;
		st_nxt.ready = 1'b0;
		st_nxt.err = 1'b0;
		st_nxt.ctl[CTL_RELEASE1] = 1'b0;

		// APB access phase, one wait state
		if (psel && penable && !st_r.ready)
		begin
			st_nxt.ready = 1'b1;
			st_nxt.err = ~mapped(paddr);
			wr_en = pwrite && mapped(paddr);
			rd_en = ~pwrite;
		end
		if (rd_en)
		begin
			st_nxt.rdata = 32'h00000000;
			if (addr_hit(paddr, ADDR_RESET_CTL))
				st_nxt.rdata[7:0] = st_r.rst_ctl;
			if (addr_hit(paddr, ADDR_CONTROL))
				st_nxt.rdata[7:0] = st_r.ctl;
			if (addr_hit(paddr, ADDR_STATUS))
				st_nxt.rdata[4:0] = {cmp_lvl, stp_lvl, st_r.stop2, st_r.stop1,
					st_r.drv.oe};
			if (addr_hit(paddr, ADDR_IRQ_STAT))
				st_nxt.rdata[NUM_EV-1:0] = st_r.ev_stat;
			if (addr_hit(paddr, ADDR_IRQ_MASK))
				st_nxt.rdata[NUM_EV-1:0] = st_r.ev_mask;
			if (addr_hit(paddr, ADDR_PERIOD))
				st_nxt.rdata[CNT_W-1:0] = st_r.period;
			if (addr_hit(paddr, ADDR_DUTY))
				st_nxt.rdata[CNT_W-1:0] = st_r.duty;
		end
		if (wr_en)
		begin
			if (addr_hit(paddr, ADDR_RESET_CTL))
				st_nxt.rst_ctl = {7'h00, pwdata[RST_BIT]};
			if (addr_hit(paddr, ADDR_CONTROL))
				st_nxt.ctl = {5'h00, pwdata[2:0]};
			if (addr_hit(paddr, ADDR_IRQ_STAT))
				w1c = pwdata[NUM_EV-1:0];
			if (addr_hit(paddr, ADDR_IRQ_MASK))
				st_nxt.ev_mask = pwdata[NUM_EV-1:0];
			if (addr_hit(paddr, ADDR_PERIOD))
				st_nxt.period = pwdata[CNT_W-1:0];
			if (addr_hit(paddr, ADDR_DUTY))
				st_nxt.duty = pwdata[CNT_W-1:0];
		end

		timer_rst = st_r.rst_ctl[RST_BIT];

		// Interval tick, independent of the PWM timer
		if (st_r.tick_cnt >= TICK_COUNT - 1)
		begin
			st_nxt.tick_cnt = 32'h00000000;
			ev[EV_TICK] = 1'b1;
		end
		else
			st_nxt.tick_cnt = st_r.tick_cnt + 32'h00000001;

		ev[EV_CMP_RISE] = cmp_rise;
		ev[EV_CMP_FALL] = cmp_fall;

		if (timer_rst)
		begin
			st_nxt.cnt = '0;
			st_nxt.stop1 = 1'b0;
			st_nxt.stop2 = 1'b0;
			st_nxt.stop1_rel = 1'b0;
			st_nxt.stop2_rel = 1'b0;
		end
		else
		begin
			period_end = (st_r.cnt >= st_r.period - 1'b1);
			if (rs_rise)
			begin
				st_nxt.cnt = '0;
				ev[EV_RESTART] = 1'b1;
			end
			else if (period_end)
				st_nxt.cnt = '0;
			else
				st_nxt.cnt = st_r.cnt + 1'b1;
			ev[EV_PERIOD] = period_end;

			// Stop one: type 4, comparator sourced, software release
			if (st_r.stop1 && st_r.stop1_rel && period_end)
			begin
				st_nxt.stop1 = 1'b0;
				st_nxt.stop1_rel = 1'b0;
			end
			if (st_r.stop1 && wr_en && addr_hit(paddr, ADDR_CONTROL) &&
				pwdata[CTL_RELEASE1] && !cmp_lvl)
				st_nxt.stop1_rel = 1'b1;
			if (cmp_rise)
			begin
				st_nxt.stop1 = 1'b1;
				st_nxt.stop1_rel = 1'b0;
				ev[EV_STOP1] = 1'b1;
			end

			// Stop two: type 2, pin sourced, release after pin rise
			if (st_r.stop2 && st_r.stop2_rel && period_end)
			begin
				st_nxt.stop2 = 1'b0;
				st_nxt.stop2_rel = 1'b0;
			end
			if (st_r.stop2 && stp_rise)
				st_nxt.stop2_rel = 1'b1;
			if (stp_fall)
			begin
				st_nxt.stop2 = 1'b1;
				st_nxt.stop2_rel = 1'b0;
				ev[EV_STOP2] = 1'b1;
			end
		end

		// Output stage
		wave = (st_r.cnt < st_r.duty) ^ st_r.ctl[CTL_ACTIVE_LOW];
		if (timer_rst)
		begin
			st_nxt.drv.oe = 1'b1;
			st_nxt.drv.out = st_r.ctl[CTL_DEFAULT_LVL];
		end
		else if (st_r.stop1)
		begin
			st_nxt.drv.oe = 1'b0;
			st_nxt.drv.out = 1'b0;
		end
		else if (st_r.stop2)
		begin
			st_nxt.drv.oe = 1'b1;
			st_nxt.drv.out = 1'b0;
		end
		else
		begin
			st_nxt.drv.oe = 1'b1;
			st_nxt.drv.out = wave;
		end

		// Sticky events, set wins over clear
		st_nxt.ev_stat = (st_r.ev_stat & ~w1c) | ev;
		st_nxt.irq = |(st_nxt.ev_stat & st_nxt.ev_mask);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= '0;
			st_r.rst_ctl <= RESET_CTL_RST;
			st_r.ctl <= CONTROL_RST;
			st_r.period <= CNT_W'(PWM_PERIOD_CYC);
			st_r.duty <= CNT_W'(PWM_HIGH_CYC);
			st_r.drv.oe <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign prdata = st_r.rdata;
	assign pready = st_r.ready;
	assign pslverr = st_r.err;
	assign pwm_out_one = st_r.drv.out;
	assign pwm_out_one_oe = st_r.drv.oe;
	assign irq = st_r.irq;
endmodule

// file: tb/pin_model.sv
// Far-side pins: comparator output, stop and restart triggers
`timescale 1ns/100ps
module pin_model
(
	input wire logic cq,
	input wire logic sq,
	input wire logic kq,
	output logic overcurrent_comparator,
	output logic stop_trigger_input,
	output logic restart_trigger_input
);
	assign overcurrent_comparator = cq;
	// Stop pin idles high
	assign stop_trigger_input = !sq;
	assign restart_trigger_input = kq;
endmodule

// file: tb/pwm_stop_monitor.sv
// Checker on PWM stop pins and APB
`timescale 1ns/100ps
module pwm_stop_monitor
	import pwm_stop_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic overcurrent_comparator,
	input wire logic stop_trigger_input,
	input wire logic pwm_out_one,
	input wire logic pwm_out_one_oe
);
	logic hold_r;
	logic dflt_r;
	logic [15:0] hi_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hold_r <= 1'b1;
			dflt_r <= CONTROL_RST[CTL_DEFAULT_LVL];
			hi_r <= 16'h0;
		end
		else
		begin
			if (psel && penable && pwrite && !pready && paddr[7:0] == ADDR_RESET_CTL)
				hold_r <= pwdata[RST_BIT];
			if (psel && penable && pwrite && !pready && paddr[7:0] == ADDR_CONTROL)
				dflt_r <= pwdata[CTL_DEFAULT_LVL];
			hi_r <= pwm_out_one ? hi_r + 16'h1 : 16'h0;
		end
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_hiz;
		$rose(overcurrent_comparator) && !hold_r |-> ##[3:6] !pwm_out_one_oe;
	endproperty
	a_hiz: assert property (p_hiz) else $error("hiz");
	property p_low;
		(!stop_trigger_input && !hold_r) [*8] |-> !(pwm_out_one && pwm_out_one_oe);
	endproperty
	a_low: assert property (p_low) else $error("low");
	property p_keep;
		!pwm_out_one_oe && overcurrent_comparator && !hold_r |=> !pwm_out_one_oe;
	endproperty
	a_keep: assert property (p_keep) else $error("keep");
	property p_hold;
		hold_r [*4] |-> pwm_out_one == $past(dflt_r) && pwm_out_one_oe;
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_duty;
		$fell(pwm_out_one) && pwm_out_one_oe && stop_trigger_input && !hold_r
			|-> hi_r == 16'(PWM_HIGH_CYC);
	endproperty
	a_duty: assert property (p_duty) else $error("duty");
	property p_ready;
		psel && !penable |=> !pready ##1 pready;
	endproperty
	a_ready: assert property (p_ready) else $error("ready");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse");
	property p_err;
		pslverr |-> pready && paddr[7:0] > ADDR_DUTY;
	endproperty
	a_err: assert property (p_err) else $error("err");
endmodule
bind pwm_forced_output_stop pwm_stop_monitor mon_u (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .overcurrent_comparator,
	.stop_trigger_input, .pwm_out_one, .pwm_out_one_oe);

// file: tb/tb_pwm_forced_output_stop.sv
// Bench: defaults, PWM, stops, restart, irq
`timescale 1ns/100ps
module tb_pwm_forced_output_stop
	import pwm_stop_pkg::*;
();
	logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
	logic cq = '0, sq = '0, kq = '0, err;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
	logic pready, pslverr, pwm_out_one, pwm_out_one_oe, irq;
	logic overcurrent_comparator, stop_trigger_input, restart_trigger_input;
	int errors = 0, check_count = 0;
	typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_t;
	row_t rows [3] = '{'{ADDR_RESET_CTL, 32'h1, 1'b0},
		'{ADDR_PERIOD, 32'(PWM_PERIOD_CYC), 1'b0}, '{8'h1c, 32'h0, 1'b1}};
	pin_model pin_u (.cq, .sq, .kq, .overcurrent_comparator, .stop_trigger_input,
		.restart_trigger_input);
	pwm_forced_output_stop #(.TICK_COUNT(50)) dut_u (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .overcurrent_comparator,
		.stop_trigger_input, .restart_trigger_input, .pwm_out_one, .pwm_out_one_oe, .irq);
	initial forever #2.5 pclk = ~pclk;
	task automatic chk(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic finish_test();
		if (errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic hang();
		errors++;
		finish_test();
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel <= '1;
		pwrite <= w;
		paddr <= 32'(a);
		pwdata <= d;
		tick(1);
		penable <= '1;
		do
		begin
			tick(1);
			n++;
		end
		while (pready !== 1'b1 && n < 9);
		if (pready !== 1'b1)
			hang();
		rd = prdata;
		err = pslverr;
		psel <= '0;
		penable <= '0;
		tick(1);
	endtask
	task automatic wt(input logic oe, input logic v);
		int n = 0;
		while ((oe ? pwm_out_one_oe : pwm_out_one) !== v)
		begin
			tick(1);
			n++;
			if (n > 9000)
				hang();
		end
	endtask
	initial
	begin
		tick(5);
		presetn <= '1;
		tick(3);
		foreach (rows[i])
		begin
			apb('0, rows[i].a, '0);
			chk("rd", rows[i].d, rd);
			chk("slverr", 32'(rows[i].e), 32'(err));
		end
		apb('1, ADDR_RESET_CTL, '0);
		wt('0, '1);
		wt('0, '0);
		kq <= '1;
		tick(3);
		kq <= '0;
		tick(9);
		chk("out", 32'h1, 32'(pwm_out_one));
		sq <= '1;
		tick(12);
		chk("out", 32'h0, 32'(pwm_out_one));
		chk("irq", 32'h0, 32'(irq));
		apb('1, ADDR_IRQ_MASK, 32'h2);
		tick(2);
		chk("irq", 32'h1, 32'(irq));
		apb('1, ADDR_IRQ_STAT, 32'h2);
		tick(2);
		chk("irq", 32'h0, 32'(irq));
		sq <= '0;
		tick(20);
		chk("out", 32'h0, 32'(pwm_out_one));
		wt('0, '1);
		cq <= '1;
		tick(12);
		chk("oe", 32'h0, 32'(pwm_out_one_oe));
		apb('1, ADDR_CONTROL, 32'h1);
		tick(4100);
		chk("oe", 32'h0, 32'(pwm_out_one_oe));
		cq <= '0;
		tick(8);
		apb('1, ADDR_CONTROL, 32'h1);
		wt('1, '1);
		chk("out", 32'h1, 32'(pwm_out_one));
		cq <= '1;
		tick(12);
		cq <= '0;
		tick(8);
		apb('1, ADDR_RESET_CTL, 32'h1);
		tick(2);
		chk("oe", 32'h1, 32'(pwm_out_one_oe));
		chk("out", 32'h0, 32'(pwm_out_one));
		apb('1, ADDR_CONTROL, 32'h2);
		tick(2);
		chk("out", 32'h1, 32'(pwm_out_one));
		apb('1, ADDR_CONTROL, 32'h4);
		apb('1, ADDR_RESET_CTL, '0);
		tick(4);
		chk("out", 32'h0, 32'(pwm_out_one));
		wt('0, '1);
		apb('1, ADDR_IRQ_MASK, 32'h20);
		tick(2);
		chk("irq", 32'h1, 32'(irq));
		presetn <= '0;
		tick(2);
		presetn <= '1;
		tick(2);
		chk("oe", 32'h1, 32'(pwm_out_one_oe));
		chk("out", 32'h0, 32'(pwm_out_one));
		chk("irq", 32'h0, 32'(irq));
		apb('0, ADDR_RESET_CTL, '0);
		chk("rd", 32'h1, rd);
		finish_test();
	end
endmodule
